// file: rtl/agm_pkg.sv
// constants for the address/gpio and clock-out pin multiplexer
package agm_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_CKO_SEL = 6'h00;
    localparam logic [5:0] OFS_CORE_CLK = 6'h04;
    localparam logic [5:0] OFS_BUS_CTRL = 6'h08;
    localparam logic [5:0] OFS_PIN_FUNC = 6'h0C;
    localparam logic [5:0] OFS_GPIO_DIR = 6'h10;
    localparam logic [5:0] OFS_GPIO_OUT = 6'h14;
    localparam logic [5:0] OFS_GPIO_IN = 6'h18;
    localparam logic [5:0] OFS_PUR_A = 6'h1C;
    localparam logic [5:0] OFS_PUR_E = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;

    // field positions
    localparam int BIT_PLL_REF = 0;
    localparam int BIT_DRIVE_KEEP = 0;
    localparam int BIT_ST_OSC_EXT = 0;
    localparam int BIT_ST_BUS_ACT = 1;

    // shared pin count and port bit of each shared pin
    localparam int NPIN = 9;
    localparam int PA_LOW_BASE = 8;
    localparam int PE_BASE = 2;
    localparam int PA_A8_BIT = 0;

    // values after reset
    localparam logic [2:0] RST_CKO_SEL = 3'h0;
    localparam logic RST_PLL_REF = 1'b0;
    localparam logic RST_DRIVE_KEEP = 1'b0;
    localparam logic [8:0] RST_PIN_FUNC = 9'h1FF;
    localparam logic [8:0] RST_GPIO_DIR = 9'h000;
    localparam logic [8:0] RST_GPIO_OUT = 9'h000;
    localparam logic [15:0] RST_PUR = 16'hFFFF;

    // clock-out selector codes
    typedef enum logic [2:0] {
        CKO_OFF = 3'h0,
        CKO_MSTR = 3'h1,
        CKO_PERIPH = 3'h2,
        CKO_OSC = 3'h3,
        CKO_PRESCALE = 3'h4,
        CKO_POSTSCALE = 3'h5,
        CKO_TEST0 = 3'h6,
        CKO_TEST1 = 3'h7
    } agm_cko_sel_t;
endpackage

// file: rtl/agm_pin_sync.sv
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module agm_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw and filtered levels
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_r <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign level_o = level_r;
endmodule
`default_nettype wire

// file: rtl/agm_pin_mux.sv
// address/gpio pin multiplexer and clock-out selector, wishbone registers
//
// Behaviour
// - the clock-out pin drives a clock picked by software: off, master, peripheral bus, oscillator, prescaler or postscaler.
// - further selector codes route test clocks to the clock-out pin and are not meant for normal use.
// - software chooses whether the oscillator clock feeds the core directly or is the PLL reference.
// - address lines 0 to 5 drive external memory address bits and otherwise act as port A bits 8 to 13.
// - every shared pin is separately a gpio input or output once taken away from its address function.
// - address lines 6 and 7 share pins with port E bits 2 and 3, whose inputs are schmitt filtered.
// - address line 8 drives an address bit and shares its pin with port A bit 0.
// - after reset every shared pin is in its address function.
// - with the drive-keep bit clear the address and bus control drivers float while the bus is idle.
// - clearing bit n of the port A pull-up register turns off the pull-up on port A pin n.
// - clearing bit n of the port E pull-up register turns off the pull-up on port E pin n.
// - the clock-mode pin at one takes an external clock on the crystal-out pin, at zero runs the crystal oscillator.
`timescale 1ns/100ps
`default_nettype none
module agm_pin_mux #(
    parameter int NP = 9
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // external memory interface side
    input wire logic [NP-1:0] xmem_addr_i,
    input wire logic xmem_bus_active_i,
    output logic xmem_ctrl_oe_o,
    // shared pins, index n is address line n
    input wire logic [NP-1:0] pin_in_i,
    output logic [NP-1:0] pin_out_o,
    output logic [NP-1:0] pin_oe_o,
    output logic [NP-1:0] pin_pullup_en_o,
    // clock sources and clock-out pin
    input wire logic master_system_clock_i,
    input wire logic periph_clk_i,
    input wire logic osc_clk_i,
    input wire logic prescale_clk_i,
    input wire logic postscale_clk_i,
    input wire logic [1:0] test_clk_i,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe_o,
    // oscillator and core clock control
    input wire logic osc_source_select_i,
    output logic osc_ext_clock_o,
    output logic osc_crystal_en_o,
    output logic core_clk_pll_ref_o
);
    logic [2:0] clock_out_select_reg_r;
    logic pll_ref_r;
    logic bus_drive_keep_r;
    logic [8:0] pin_func_r;
    logic [8:0] gpio_dir_r;
    logic [8:0] gpio_out_r;
    logic [15:0] port_a_pullup_enable_r;
    logic [15:0] port_e_pullup_enable_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;
    logic [NP-1:0] pin_out_r;
    logic [NP-1:0] pin_oe_r;
    logic [NP-1:0] pur_sel;
    logic [NP-1:0] pin_level;
    logic [1:0] mode_level;
    logic osc_ext_r;
    logic ctrl_oe_r;
    logic cko_oe_r;
    logic cko_mux;
    logic wr_go;
    logic bus_drive;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // pull-up bit of the owning port for shared pin n
    function automatic logic pur_of(input int n,
                                    input logic [15:0] pa,
                                    input logic [15:0] pe);
        logic res;
        res = 1'b1;
        if (n < 6) begin
            res = pa[agm_pkg::PA_LOW_BASE + n];
        end else if (n < 8) begin
            res = pe[agm_pkg::PE_BASE + n - 6];
        end else begin
            res = pa[agm_pkg::PA_A8_BIT];
        end
        return res;
    endfunction

    // pin inputs, schmitt pins included, and the clock-mode strap
    agm_pin_sync #(
        .W(NP)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_in_i),
        .level_o(pin_level)
    );

    agm_pin_sync #(
        .W(2)
    ) u_mode_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({xmem_bus_active_i, osc_source_select_i}),
        .level_o(mode_level)
    );

    // wishbone: ack one cycle after the request, write lands with ack
    assign wr_go = cyc_i && stb_i && we_i && ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= cyc_i && stb_i && !ack_r;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (adr_i)
            agm_pkg::OFS_CKO_SEL: rd_nxt[2:0] = clock_out_select_reg_r;
            agm_pkg::OFS_CORE_CLK: rd_nxt[agm_pkg::BIT_PLL_REF] = pll_ref_r;
            agm_pkg::OFS_BUS_CTRL: begin
                rd_nxt[agm_pkg::BIT_DRIVE_KEEP] = bus_drive_keep_r;
            end
            agm_pkg::OFS_PIN_FUNC: rd_nxt[8:0] = pin_func_r;
            agm_pkg::OFS_GPIO_DIR: rd_nxt[8:0] = gpio_dir_r;
            agm_pkg::OFS_GPIO_OUT: rd_nxt[8:0] = gpio_out_r;
            agm_pkg::OFS_GPIO_IN: rd_nxt[8:0] = pin_level;
            agm_pkg::OFS_PUR_A: rd_nxt[15:0] = port_a_pullup_enable_r;
            agm_pkg::OFS_PUR_E: rd_nxt[15:0] = port_e_pullup_enable_r;
            agm_pkg::OFS_STATUS: begin
                rd_nxt[agm_pkg::BIT_ST_OSC_EXT] = mode_level[0];
                rd_nxt[agm_pkg::BIT_ST_BUS_ACT] = mode_level[1];
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_r) begin
            dat_r <= rd_nxt;
        end
    end

    // clock selection registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_out_select_reg_r <= agm_pkg::RST_CKO_SEL;
            pll_ref_r <= agm_pkg::RST_PLL_REF;
        end else if (wr_go && adr_i == agm_pkg::OFS_CKO_SEL && sel_i[0]) begin
            clock_out_select_reg_r <= dat_i[2:0];
        end else if (wr_go && adr_i == agm_pkg::OFS_CORE_CLK && sel_i[0]) begin
            pll_ref_r <= dat_i[agm_pkg::BIT_PLL_REF];
        end
    end

    // bus drive control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_drive_keep_r <= agm_pkg::RST_DRIVE_KEEP;
        end else if (wr_go && adr_i == agm_pkg::OFS_BUS_CTRL && sel_i[0]) begin
            bus_drive_keep_r <= dat_i[agm_pkg::BIT_DRIVE_KEEP];
        end
    end

    // pin function and gpio registers, address function after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_func_r <= agm_pkg::RST_PIN_FUNC;
            gpio_dir_r <= agm_pkg::RST_GPIO_DIR;
            gpio_out_r <= agm_pkg::RST_GPIO_OUT;
        end else if (wr_go) begin
            if (adr_i == agm_pkg::OFS_PIN_FUNC) begin
                pin_func_r <= 9'(merge({23'h0, pin_func_r}, dat_i, sel_i));
            end
            if (adr_i == agm_pkg::OFS_GPIO_DIR) begin
                gpio_dir_r <= 9'(merge({23'h0, gpio_dir_r}, dat_i, sel_i));
            end
            if (adr_i == agm_pkg::OFS_GPIO_OUT) begin
                gpio_out_r <= 9'(merge({23'h0, gpio_out_r}, dat_i, sel_i));
            end
        end
    end

    // pull-up enable registers, all on after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_a_pullup_enable_r <= agm_pkg::RST_PUR;
            port_e_pullup_enable_r <= agm_pkg::RST_PUR;
        end else if (wr_go) begin
            if (adr_i == agm_pkg::OFS_PUR_A) begin
                port_a_pullup_enable_r <= 16'(merge(
                    {16'h0, port_a_pullup_enable_r}, dat_i, sel_i));
            end
            if (adr_i == agm_pkg::OFS_PUR_E) begin
                port_e_pullup_enable_r <= 16'(merge(
                    {16'h0, port_e_pullup_enable_r}, dat_i, sel_i));
            end
        end
    end

    // drivers float while idle unless drive-keep is set
    // bus active is same-clock logic: no sync, so no late enable
    assign bus_drive = xmem_bus_active_i || bus_drive_keep_r;

    generate
        for (genvar n = 0; n < NP; n++) begin : g_pin
            assign pur_sel[n] = pur_of(n, port_a_pullup_enable_r,
                                       port_e_pullup_enable_r);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_out_r[n] <= 1'b0;
                    pin_oe_r[n] <= 1'b0;
                end else if (pin_func_r[n]) begin
                    pin_out_r[n] <= xmem_addr_i[n];
                    pin_oe_r[n] <= bus_drive;
                end else begin
                    pin_out_r[n] <= gpio_out_r[n];
                    pin_oe_r[n] <= gpio_dir_r[n];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_oe_r <= 1'b0;
            osc_ext_r <= 1'b0;
            cko_oe_r <= 1'b0;
        end else begin
            ctrl_oe_r <= bus_drive;
            osc_ext_r <= mode_level[0];
            cko_oe_r <= clock_out_select_reg_r != agm_pkg::CKO_OFF;
        end
    end

    // clock-out mux; test codes route the test clocks
    always_comb begin
        cko_mux = 1'b0;
        unique case (agm_pkg::agm_cko_sel_t'(clock_out_select_reg_r))
            agm_pkg::CKO_OFF: cko_mux = 1'b0;
            agm_pkg::CKO_MSTR: cko_mux = master_system_clock_i;
            agm_pkg::CKO_PERIPH: cko_mux = periph_clk_i;
            agm_pkg::CKO_OSC: cko_mux = osc_clk_i;
            agm_pkg::CKO_PRESCALE: cko_mux = prescale_clk_i;
            agm_pkg::CKO_POSTSCALE: cko_mux = postscale_clk_i;
            agm_pkg::CKO_TEST0: cko_mux = test_clk_i[0];
            agm_pkg::CKO_TEST1: cko_mux = test_clk_i[1];
        endcase
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign xmem_ctrl_oe_o = ctrl_oe_r;
    assign pin_out_o = pin_out_r;
    assign pin_oe_o = pin_oe_r;
    assign pin_pullup_en_o = pur_sel;
    assign clock_out_pin_o = cko_oe_r && !rst_i && cko_mux;
    assign clock_out_pin_oe_o = cko_oe_r;
    assign osc_ext_clock_o = osc_ext_r;
    assign osc_crystal_en_o = !osc_ext_r;
    assign core_clk_pll_ref_o = pll_ref_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wr_func;
        cyc_i && stb_i && we_i && ack_r && adr_i == agm_pkg::OFS_PIN_FUNC;
    endsequence

    a_reset_drivers_off: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> (pin_oe_r == '0 && !cko_oe_r && pur_sel == '1))
        else $error("drivers or pull-ups wrong after reset");
    a_reset_addr_func: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> pin_func_r == agm_pkg::RST_PIN_FUNC)
        else $error("pins not in address function after reset");
    a_idle_float: assert property (
        pin_func_r[0] && !bus_drive |=> !pin_oe_r[0])
        else $error("address driver on while bus idle");
    a_keep_driven: assert property (
        pin_func_r[0] && bus_drive_keep_r |=> pin_oe_r[0])
        else $error("address driver off with drive-keep set");
    a_addr_follows: assert property (
        pin_func_r[3] |=> pin_out_r[3] == $past(xmem_addr_i[3]))
        else $error("address bit not forwarded");
    a_addr8_follows: assert property (
        pin_func_r[8] |=> pin_out_r[8] == $past(xmem_addr_i[8]))
        else $error("address line 8 not forwarded");
    a_gpio_mode: assert property (
        !pin_func_r[6] |=> pin_oe_r[6] == $past(gpio_dir_r[6]))
        else $error("gpio direction not applied");
    a_pur_porta: assert property (
        pin_pullup_en_o[0] == port_a_pullup_enable_r[8])
        else $error("port A pull-up bit 8 not on pin 0");
    a_pur_porte: assert property (
        pin_pullup_en_o[6] == port_e_pullup_enable_r[2])
        else $error("port E pull-up bit 2 not on pin 6");
    a_clock_out_pin_off: assert property (
        clock_out_select_reg_r == agm_pkg::CKO_OFF |=> !clock_out_pin_oe_o)
        else $error("clock-out driven while off");
    a_pll_write: assert property (
        wr_go && adr_i == agm_pkg::OFS_CORE_CLK && sel_i[0]
        |=> core_clk_pll_ref_o == $past(dat_i[0]))
        else $error("core clock source not written");
    a_osc_mode: assert property (
        ##1 osc_ext_clock_o == $past(mode_level[0])
            && osc_crystal_en_o != osc_ext_clock_o)
        else $error("oscillator source not following strap");
    a_func_write: assert property (s_wr_func ##0 sel_i[0]
        |=> pin_func_r[7:0] == $past(dat_i[7:0]) ##1 !ack_r)
        else $error("pin function write lost");
endmodule
`default_nettype wire

// file: tb/agm_ext_mem.sv
// far-side pin model: external drivers, pull-ups and pin wiring
`timescale 1ns/100ps
`default_nettype none
module agm_ext_mem (
    // clock
    input wire logic clk_i,
    // device side of the shared pins
    input wire logic [8:0] pin_out_i,
    input wire logic [8:0] pin_oe_i,
    input wire logic [8:0] pullup_i,
    // external drivers commanded by the bench
    input wire logic [8:0] ext_val_i,
    input wire logic [8:0] ext_oe_i,
    // resolved wire levels
    output logic [8:0] level_o
);
    logic [8:0] float_r = 9'h155;

    // undriven pins without pull-up wander every cycle
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end

    always_comb begin
        for (int n = 0; n < 9; n++) begin
            if (pin_oe_i[n]) begin
                level_o[n] = pin_out_i[n];
            end else if (ext_oe_i[n]) begin
                level_o[n] = ext_val_i[n];
            end else if (pullup_i[n]) begin
                level_o[n] = 1'b1;
            end else begin
                level_o[n] = float_r[n];
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/address_gpio_clock_pin_mux_tb_top.sv
// testbench for the address/gpio and clock-out pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module address_gpio_clock_pin_mux_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd;
    logic [31:0] dat_o;
    logic ack_o, ctrl_oe, cko, cko_oe, osc_ext, crystal_en, pll_ref;
    logic [8:0] xmem_addr = 9'h000, ext_val = 9'h000, ext_oe = 9'h000;
    logic bus_act = 1'b0, osc_sel = 1'b0;
    logic [8:0] lvl, p_out, p_oe, p_pu;
    logic m = 0, pb = 0, osc = 0, pre = 0, post = 0;
    logic [1:0] tst = 2'h0;
    int error_cnt = 0, n_tests = 0, cyc_cnt = 0;
    logic [5:0] ra [8] = '{agm_pkg::OFS_CKO_SEL, agm_pkg::OFS_CORE_CLK,
        agm_pkg::OFS_BUS_CTRL, agm_pkg::OFS_PIN_FUNC, agm_pkg::OFS_GPIO_DIR,
        agm_pkg::OFS_GPIO_OUT, agm_pkg::OFS_PUR_A, agm_pkg::OFS_PUR_E};
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h1FF, 32'h0, 32'h0,
        32'hFFFF, 32'hFFFF};

    always #2.5 clk_i = ~clk_i;
    always #3 m = ~m;
    always #4 pb = ~pb;
    always #6 osc = ~osc;
    always #7 pre = ~pre;
    always #9 post = ~post;
    always #11 tst[0] = ~tst[0];
    always #13 tst[1] = ~tst[1];

    agm_pin_mux DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .xmem_addr_i(xmem_addr),
        .xmem_bus_active_i(bus_act), .xmem_ctrl_oe_o(ctrl_oe),
        .pin_in_i(lvl), .pin_out_o(p_out),
        .pin_oe_o(p_oe), .pin_pullup_en_o(p_pu), .master_system_clock_i(m),
        .periph_clk_i(pb), .osc_clk_i(osc), .prescale_clk_i(pre),
        .postscale_clk_i(post), .test_clk_i(tst), .clock_out_pin_o(cko),
        .clock_out_pin_oe_o(cko_oe), .osc_source_select_i(osc_sel),
        .osc_ext_clock_o(osc_ext), .osc_crystal_en_o(crystal_en),
        .core_clk_pll_ref_o(pll_ref));

    agm_ext_mem far (.clk_i(clk_i), .pin_out_i(p_out), .pin_oe_i(p_oe),
        .pullup_i(p_pu), .ext_val_i(ext_val), .ext_oe_i(ext_oe),
        .level_o(lvl));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle; ack and read data taken at the same edge
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, rd);
        chk(rd, e, "register read");
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic rst_chk;
        chk(p_oe, 9'h000, "oe in reset");
        chk(p_pu, 9'h1FF, "pull-ups in reset");
        chk({cko, cko_oe}, 2'h0, "clock out in reset");
    endtask

    function automatic logic src(input int s);
        case (s)
            1: return m;
            2: return pb;
            3: return osc;
            4: return pre;
            5: return post;
            6: return tst[0];
            7: return tst[1];
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        settle(2);
        rst_chk();
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(ra[i], rv[i]);
        end
        rd_chk(6'h3C, 32'h0);
        $display("test reset values done");

        xmem_addr <= 9'h1A5;
        settle(8);
        chk(p_oe, 9'h000, "idle address pins");
        chk(ctrl_oe, 1'b0, "idle control");
        @(posedge clk_i);
        bus_act <= 1'b1;
        settle(2);
        chk(p_oe, 9'h1FF, "active address oe");
        chk(p_out, 9'h1A5, "address value");
        chk(ctrl_oe, 1'b1, "active control");
        @(posedge clk_i);
        xmem_addr <= 9'h05A;
        @(posedge clk_i);
        settle(1);
        chk(p_out, 9'h05A, "address one cycle");
        @(posedge clk_i);
        bus_act <= 1'b0;
        wr(agm_pkg::OFS_BUS_CTRL, 32'h1);
        settle(8);
        chk(p_oe, 9'h1FF, "kept drive");
        chk(ctrl_oe, 1'b1, "kept control");
        $display("test address bus done");

        wr(agm_pkg::OFS_GPIO_DIR, 32'h0AA);
        wr(agm_pkg::OFS_GPIO_OUT, 32'h0F0);
        ext_val <= 9'h1C3;
        ext_oe <= 9'h155;
        wr(agm_pkg::OFS_PIN_FUNC, 32'h000);
        settle(8);
        chk(p_oe, 9'h0AA, "gpio oe");
        chk(p_out & 9'h0AA, 9'h0A0, "gpio out");
        rd_chk(agm_pkg::OFS_GPIO_IN, 32'h1E1);
        ext_oe <= 9'h000;
        settle(8);
        rd_chk(agm_pkg::OFS_GPIO_IN, 32'h1F5);
        $display("test gpio done");

        wr(agm_pkg::OFS_PUR_A, 32'hFEFE);
        settle(1);
        chk(p_pu, 9'h0FE, "pull-up port a");
        wr(agm_pkg::OFS_PUR_E, 32'hFFFB);
        settle(1);
        chk(p_pu, 9'h0BE, "pull-up port e");
        $display("test pull-ups done");

        for (int s = 0; s < 8; s++) begin
            wr(agm_pkg::OFS_CKO_SEL, s);
            settle(2);
            chk(cko_oe, s != 0, "clock out enable");
            repeat (6) begin
                settle(1);
                #0.5;
                chk(cko, src(s), "clock out source");
            end
        end
        $display("test clock out done");

        wr(agm_pkg::OFS_CORE_CLK, 32'h1);
        settle(1);
        chk(pll_ref, 1'b1, "pll reference");
        wr(agm_pkg::OFS_CORE_CLK, 32'h0);
        settle(1);
        chk(pll_ref, 1'b0, "core direct");
        @(posedge clk_i);
        osc_sel <= 1'b1;
        settle(8);
        chk({osc_ext, crystal_en}, 2'h2, "external clock mode");
        rd_chk(agm_pkg::OFS_STATUS, 32'h1);
        $display("test clock mode done");

        @(posedge clk_i);
        rst_i <= 1'b1;
        settle(2);
        rst_chk();
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(agm_pkg::OFS_PIN_FUNC, 32'h1FF);
        rd_chk(agm_pkg::OFS_BUS_CTRL, 32'h0);
        chk(p_oe, 9'h000, "oe after second reset");
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
